// file: src/frame_mode_reg_master.sv
// Purpose: synchronous serial unit, four-wire master that reads a serial memory
// Assumes: one 200 MHz clock; pins in from outside pass two flip-flops
// Notes:   control bits are plain ports; received words wait in a two-entry buffer
`timescale 1ns/1ps

// ==============================================================
// top
module frame_mode_reg_master
	import frame_mode_reg_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        soft_reset,
	input  wire logic        master_mode,
	input  wire logic        clk_polarity,
	input  wire logic        clk_phase,
	input  wire logic        msb_first,
	input  wire logic [2:0]  rate_sel,
	input  wire logic [1:0]  data_len_sel,
	input  wire logic        tx_on,
	input  wire logic        rx_on,
	input  wire logic [2:0]  irq_enable,
	input  wire logic [2:0]  open_drain_sel,
	input  wire logic        cs_auto,
	input  wire logic        cs_setup_delay,
	input  wire logic        so_hold_idle,
	input  wire logic        done_after_last,
	input  wire logic        select_level,
	input  wire logic        tx_write,
	input  wire logic [31:0] tx_wdata,
	input  wire logic        done_clear,
	input  wire logic        rx_read,
	output logic      [31:0] rx_data,
	output logic             rx_buffer_full_flag,
	output logic             tx_buffer_empty_flag,
	output logic             tx_done_flag,
	output logic             busy,
	output logic      [2:0]  irq_req,
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe_n,
	output logic             serial_out_pin_out,
	output logic             serial_out_pin_oe_n,
	input  wire logic        serial_in_pin,
	output logic             chip_select_pin_out,
	output logic             chip_select_pin_oe_n,
	output logic             select_port_pin
);
	// ==========================================================
	// helpers
	function automatic logic [5:0] frame_bits(input logic [1:0] len);
		return 6'((7'(len) + 7'h01) << 3);
	endfunction

	function automatic logic [7:0] half_limit(input logic [2:0] sel);
		return 8'((16'h0001 << sel) - 16'h0001);
	endfunction

	function automatic logic [31:0] shift_in(input logic [31:0] s, input logic b,
			input logic msb);
		return msb ? {s[30:0], b} : {b, s[31:1]};
	endfunction

	// msb first sends from the top, so a short frame is left aligned
	function automatic logic [31:0] align_tx(input logic [31:0] d,
			input logic [5:0] n, input logic msb);
		return msb ? (d << (6'd32 - n)) : d;
	endfunction

	function automatic logic [31:0] extract_rx(input logic [31:0] s,
			input logic [5:0] n, input logic msb);
		return msb ? (s & ~(DUMMY_WORD << n)) : (s >> (6'd32 - n));
	endfunction

	// ==========================================================
	// pin synchronisers; first stages feed only the second stages
	logic sck_sync1_reg, sck_sync2_reg, sck_prev_reg;
	logic si_sync1_reg, si_sync2_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sck_sync1_reg <= clk_polarity;  // idle level, so no false edge after reset
			sck_sync2_reg <= clk_polarity;
			sck_prev_reg <= clk_polarity;
			si_sync1_reg <= 1'b1;
			si_sync2_reg <= 1'b1;
		end else begin
			sck_sync1_reg <= serial_clock_pin_in;
			sck_sync2_reg <= sck_sync1_reg;
			sck_prev_reg <= sck_sync2_reg;
			si_sync1_reg <= serial_in_pin;
			si_sync2_reg <= si_sync1_reg;
		end
	end

	// ==========================================================
	// peripheral rate enable, 40 MHz from 200 MHz
	logic [2:0] pclk_cnt_reg, pclk_cnt_next;
	logic       pclk_tick_reg, pclk_tick_next;

	always_comb begin
		pclk_tick_next = (pclk_cnt_reg == PCLK_LAST);
		pclk_cnt_next = pclk_tick_next ? 3'h0 : pclk_cnt_reg + 3'h1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pclk_cnt_reg <= 3'h0;
			pclk_tick_reg <= 1'b0;
		end else begin
			pclk_cnt_reg <= pclk_cnt_next;
			pclk_tick_reg <= pclk_tick_next;
		end
	end

	// ==========================================================
	// frame sequencer, shifter, flags and pins
	frame_mode_reg_state_type state_reg, state_next;
	logic [7:0]  half_cnt_reg, half_cnt_next;
	logic [5:0]  edge_cnt_reg, edge_cnt_next;
	logic [31:0] shift_reg, shift_next;
	logic [31:0] tx_data_reg, tx_data_next;
	logic        rx_bit_reg, rx_bit_next;
	logic        tx_empty_reg, tx_empty_next;
	logic        tx_done_reg, tx_done_next;
	logic        sck_reg, sck_next, sck_oe_n_reg, sck_oe_n_next;
	logic        so_reg, so_next, so_oe_n_reg, so_oe_n_next;
	logic        cs_reg, cs_next, cs_oe_n_reg, cs_oe_n_next;
	logic        sel_reg, busy_reg;
	logic [2:0]  irq_reg, irq_next;
	logic [5:0]  nbits, last_edge;
	logic        half_tick, edge_ev, sample, adv, adv_bit, frame_done, set_done, go;
	logic        push, buf_ready, buf_valid, has_tx, active;

	always_comb begin
		nbits = frame_bits(data_len_sel);
		last_edge = 6'((7'(nbits) << 1) - 7'h01);
		half_tick = pclk_tick_reg && (half_cnt_reg == half_limit(rate_sel));
		// master counts its own half periods, a slave follows the pin
		edge_ev = (state_reg == ST_SHIFT) &&
			(master_mode ? half_tick : (sck_sync2_reg != sck_prev_reg));
		sample = clk_phase ? edge_cnt_reg[0] : !edge_cnt_reg[0];
		frame_done = edge_ev && (edge_cnt_reg == last_edge);
		// phase 1 has no shift on the first edge but a final one at the end
		adv = edge_ev && ((!sample && !(clk_phase && edge_cnt_reg == 6'h00)) ||
			(frame_done && clk_phase));
		adv_bit = sample ? si_sync2_reg : rx_bit_reg;
		has_tx = tx_on && !tx_empty_reg;
		// a full receive buffer holds the next frame back
		go = (state_reg == ST_IDLE) && (has_tx || (!tx_on && rx_on)) &&
			(!rx_on || buf_ready);
		set_done = (done_after_last ? frame_done :
			(edge_ev && edge_cnt_reg == last_edge - 6'h01)) &&
			tx_empty_reg && !tx_write;
		push = frame_done && rx_on;  // frames while receive is off are dropped

		state_next = state_reg;
		half_cnt_next = (state_reg == ST_IDLE || half_tick) ? 8'h00 :
			half_cnt_reg + {7'h00, pclk_tick_reg};
		edge_cnt_next = edge_ev ? edge_cnt_reg + 6'h01 : edge_cnt_reg;
		rx_bit_next = (edge_ev && sample) ? si_sync2_reg : rx_bit_reg;
		shift_next = adv ? shift_in(shift_reg, adv_bit, msb_first) : shift_reg;
		tx_data_next = tx_write ? tx_wdata : tx_data_reg;
		tx_empty_next = tx_empty_reg;
		tx_done_next = tx_done_reg;

		unique case (state_reg)
			ST_IDLE: begin
				edge_cnt_next = 6'h00;
				if (go) begin
					// move the waiting word into the shifter, or ones for a dummy
					shift_next = has_tx ? align_tx(tx_data_reg, nbits, msb_first) :
						DUMMY_WORD;
					tx_empty_next = has_tx ? 1'b1 : tx_empty_reg;
					state_next = (master_mode && cs_auto && cs_setup_delay) ?
						ST_SETUP : ST_SHIFT;
				end
			end
			ST_SETUP: begin
				if (half_tick) begin
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (frame_done) begin
					state_next = ST_IDLE;
				end
			end
		endcase

		// a write wins over the load of the previous word
		if (tx_write) begin
			tx_empty_next = 1'b0;
		end
		if (tx_write || done_clear) begin
			tx_done_next = 1'b0;
		end
		if (set_done) begin
			tx_done_next = 1'b1;  // set wins over clear
		end

		active = (state_next != ST_IDLE);
		sck_next = (master_mode && active) ? (edge_ev ? !sck_reg : sck_reg) :
			clk_polarity;
		sck_oe_n_next = !master_mode || (open_drain_sel[1] && sck_next);
		so_next = active ? (msb_first ? shift_next[31] : shift_next[0]) :
			((so_hold_idle || frame_done) ? so_reg : 1'b1);  // last bit outlives final edge
		so_oe_n_next = (!master_mode && !active) || (open_drain_sel[0] && so_next);
		cs_next = !(master_mode && cs_auto && active);
		cs_oe_n_next = !(master_mode && cs_auto) || (open_drain_sel[2] && cs_next);
		irq_next = {tx_done_next, buf_valid, tx_empty_next} & irq_enable;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || soft_reset) begin
			state_reg <= ST_IDLE;
			half_cnt_reg <= 8'h00;
			edge_cnt_reg <= 6'h00;
			shift_reg <= '0;
			tx_data_reg <= TX_DATA_RESET;
			rx_bit_reg <= 1'b0;
			tx_empty_reg <= 1'b1;
			tx_done_reg <= 1'b0;
			sck_reg <= 1'b0;
			sck_oe_n_reg <= 1'b1;
			so_reg <= 1'b1;
			so_oe_n_reg <= 1'b1;
			cs_reg <= 1'b1;
			cs_oe_n_reg <= 1'b1;
			sel_reg <= 1'b1;
			busy_reg <= 1'b0;
			irq_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			half_cnt_reg <= half_cnt_next;
			edge_cnt_reg <= edge_cnt_next;
			shift_reg <= shift_next;
			tx_data_reg <= tx_data_next;
			rx_bit_reg <= rx_bit_next;
			tx_empty_reg <= tx_empty_next;
			tx_done_reg <= tx_done_next;
			sck_reg <= sck_next;
			sck_oe_n_reg <= sck_oe_n_next;
			so_reg <= so_next;
			so_oe_n_reg <= so_oe_n_next;
			cs_reg <= cs_next;
			cs_oe_n_reg <= cs_oe_n_next;
			sel_reg <= select_level;  // software held select
			busy_reg <= active;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================
	// receive buffer; the head word is the receive data register
	frame_mode_reg_pair_buffer #(
		.WIDTH(32)
	) u_rx_buffer (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.flush    (soft_reset),
		.in_valid (push),
		.in_ready (buf_ready),
		.in_data  (extract_rx(shift_next, nbits, msb_first)),
		.out_valid(buf_valid),
		.out_ready(rx_read),
		.out_data (rx_data)
	);

	assign rx_buffer_full_flag   = buf_valid;
	assign tx_buffer_empty_flag  = tx_empty_reg;
	assign tx_done_flag          = tx_done_reg;
	assign busy                  = busy_reg;
	assign irq_req               = irq_reg;
	assign serial_clock_pin_out  = sck_reg;
	assign serial_clock_pin_oe_n = sck_oe_n_reg;
	assign serial_out_pin_out    = so_reg;
	assign serial_out_pin_oe_n   = so_oe_n_reg;
	assign chip_select_pin_out   = cs_reg;
	assign chip_select_pin_oe_n  = cs_oe_n_reg;
	assign select_port_pin       = sel_reg;

	// ==========================================================
	// checks
	logic [11:0] gap_reg;
	logic        sck_tog;

	assign sck_tog = (sck_next != sck_reg) && master_mode && (state_reg == ST_SHIFT);

	// cycles since the last serial clock toggle, read only by the checks
	always_ff @(posedge clock) begin
		if (sys_rst || soft_reset || sck_tog) begin
			gap_reg <= 12'h000;
		end else begin
			gap_reg <= gap_reg + 12'h001;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || soft_reset);

	sequence s_load;
		state_reg == ST_IDLE && go && has_tx;
	endsequence
	sequence s_last_edge;
		frame_done && rx_on;
	endsequence

	a_write_clears_empty: assert property (
		tx_write |=> !tx_buffer_empty_flag)
		else $error("transmit write did not clear the empty flag");
	a_load_sets_empty: assert property (
		s_load and !tx_write |=> tx_buffer_empty_flag && state_reg != ST_IDLE)
		else $error("load did not set the empty flag");
	a_frame_fills_rx: assert property (
		s_last_edge |=> rx_buffer_full_flag ##1 (rx_buffer_full_flag || $past(rx_read)))
		else $error("completed frame did not reach the receive buffer");
	a_done_after_last: assert property (
		frame_done && done_after_last && tx_empty_reg && !tx_write
		|=> tx_done_flag)
		else $error("done flag not set after the last bit");
	a_write_clears_done: assert property (
		tx_write && !set_done |=> !tx_done_flag)
		else $error("transmit write did not clear the done flag");
	a_sck_idle_level: assert property (
		(state_reg == ST_IDLE && $stable(clk_polarity))[*2] |-> sck_reg == clk_polarity)
		else $error("serial clock not at its idle level");
	a_sck_half_period: assert property (
		sck_tog && edge_cnt_reg != 6'h00 && $stable(rate_sel)
		|-> 12'(gap_reg + 12'h001) == 12'(PCLK_DIV << rate_sel))
		else $error("serial clock half period off");
	a_cs_per_frame: assert property (
		master_mode && cs_auto && state_reg == ST_SHIFT && !frame_done |=> !chip_select_pin_out)
		else $error("automatic select not asserted during a frame");
	a_frame_length: assert property (
		state_reg == ST_SHIFT && edge_ev |-> edge_cnt_reg <= last_edge)
		else $error("frame ran past its bit count");
endmodule

// file: src/frame_mode_reg_pkg.sv
// Purpose: shared constants for the synchronous serial master/receive unit
// Assumes: 200 MHz system clock, 40 MHz peripheral rate derived by enable pulses
// Notes:   command codes are the serial memory instruction bytes

// ==============================================================
// package
package frame_mode_reg_pkg;
	// ==========================================================
	// clock rates and divider counts
	localparam int CLOCK_HZ  = 200_000_000;
	localparam int PERIPH_HZ = 40_000_000;
	localparam int SERIAL_HZ = 2_500_000;  // at the reset rate selection
	localparam int PCLK_DIV  = CLOCK_HZ / PERIPH_HZ;
	localparam logic [2:0] PCLK_LAST = 3'(PCLK_DIV - 1);
	// half period = 2^sel peripheral ticks, so sel 3 gives 40 MHz / 16
	localparam logic [2:0] RATE_SEL_RESET = 3'h3;

	// ==========================================================
	// frame layout
	localparam int WORD_BITS = 32;
	localparam logic [1:0] LEN_8BIT = 2'h0;
	localparam logic [WORD_BITS-1:0] TX_DATA_RESET = 32'h00000000;
	localparam logic [WORD_BITS-1:0] DUMMY_WORD = 32'hFFFFFFFF;
	localparam logic [2:0] IRQ_TX_EMPTY = 3'h0;  // bit positions of requests
	localparam logic [2:0] IRQ_RX_FULL  = 3'h1;
	localparam logic [2:0] IRQ_TX_DONE  = 3'h2;

	// ==========================================================
	// memory instruction bytes
	localparam logic [7:0] WRITE_LATCH_SET_CMD   = 8'h06;
	localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
	localparam logic [7:0] READ_CMD              = 8'h03;
	localparam logic [7:0] WRITE_CMD             = 8'h02;
	localparam logic [7:0] DUMMY_BYTE            = 8'hFF;

	// ==========================================================
	// frame sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_SHIFT = 2'b10
	} frame_mode_reg_state_type;
endpackage

// file: src/frame_mode_reg_pair_buffer.sv
// Purpose: two-entry buffer between the shifter and the receive reader
// Assumes: same clock on both sides
// Notes:   head word and both flags come straight from flip-flops
`timescale 1ns/1ps

// ==============================================================
// two-entry buffer
module frame_mode_reg_pair_buffer #(
	parameter int WIDTH = 32
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] head_reg, head_next;
	logic [WIDTH-1:0] tail_reg, tail_next;
	logic             valid_reg, valid_next;
	logic             full_reg, full_next;
	logic             push;
	logic             pop;

	assign in_ready  = !full_reg;
	assign out_valid = valid_reg;
	assign out_data  = head_reg;

	// next entry contents; a pop and a push in one cycle keep the word count
	always_comb begin
		push = in_valid && !full_reg;
		pop = out_ready && valid_reg;
		head_next = head_reg;
		tail_next = tail_reg;
		valid_next = valid_reg;
		full_next = full_reg;
		if (pop) begin
			head_next = full_reg ? tail_reg : (push ? in_data : head_reg);
			full_next = 1'b0;
			valid_next = full_reg || push;  // a new word wins over the read
			if (full_reg && push) begin
				tail_next = in_data;
				full_next = 1'b1;
			end
		end else if (push) begin
			valid_next = 1'b1;
			if (valid_reg) begin
				tail_next = in_data;
				full_next = 1'b1;
			end else begin
				head_next = in_data;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || flush) begin
			head_reg <= '0;
			tail_reg <= '0;
			valid_reg <= 1'b0;
			full_reg <= 1'b0;
		end else begin
			head_reg <= head_next;
			tail_reg <= tail_next;
			valid_reg <= valid_next;
			full_reg <= full_next;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || flush);

	a_read_clears_full: assert property (
		(valid_reg && !full_reg && out_ready && !in_valid) |=> !valid_reg)
		else $error("read of the only word left the full flag set");
	a_full_holds_two: assert property (full_reg |-> valid_reg)
		else $error("buffer full without a head word");
endmodule

// file: sim/frame_mode_reg_memory_model.sv
// Purpose: behavioural serial memory on the far side of the master
// Assumes: select comes from the general port pin; eight-bit instructions, msb first
// Notes:   two address bytes; only the read instruction returns data
`timescale 1ns/1ps

// ==============================================================
// serial memory model
module frame_mode_reg_memory_model
	import frame_mode_reg_pkg::*;
(
	input  wire logic sclk,
	input  wire logic select_n,
	input  wire logic mosi,
	input  wire logic cpol,
	input  wire logic cpha,
	output logic      miso
);
	int unsigned bit_cnt = 0;
	logic [7:0]  cmd_reg = 8'h00;
	logic [15:0] addr_reg = 16'h0000;
	logic [31:0] in_sr = 32'h00000000;

	initial miso = 1'b0;

	// stored contents, a plain scramble of the address
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return 8'(a[7:0] * 8'h1D) ^ a[15:8] ^ 8'h5A;
	endfunction

	// put the next bit on the line; outside data the line wanders
	task automatic present();
		logic [7:0] b;
		if (cmd_reg === READ_CMD && bit_cnt >= 24) begin
			b = mem_byte(16'(addr_reg + 16'((bit_cnt - 24) / 8)));
			miso = b[7 - (bit_cnt % 8)];
		end else begin
			miso = ~miso;
		end
	endtask

	// a new selection restarts the instruction decode
	always @(negedge select_n) begin
		bit_cnt = 0;
		cmd_reg = 8'h00;
		if (!cpha) begin
			present();
		end
	end

	// released line must not keep showing the last bit
	always @(posedge select_n) begin
		miso = ~miso;
	end

	// sample on one clock edge, shift on the other
	always @(sclk) begin
		if (select_n === 1'b0) begin
			if ((sclk !== cpol) ^ cpha) begin
				in_sr = {in_sr[30:0], mosi};
				bit_cnt++;
				if (bit_cnt == 8) cmd_reg = in_sr[7:0];
				if (bit_cnt == 24) addr_reg = in_sr[15:0];
			end else begin
				present();
			end
		end
	end
endmodule

// file: sim/tb_top.sv
// Purpose: self-checking bench for the serial master reading a serial memory
// Assumes: master mode, eight-bit frames, msb first, select held on the port pin
// Notes:   stimulus from a fixed-seed lfsr; every wait is bounded
`timescale 1ns/1ps

// ==============================================================
// bench top
module tb_top;
	import frame_mode_reg_pkg::*;
	localparam int LIMIT = 3000;
	localparam logic [7:0] CODES [6] = '{WRITE_LATCH_SET_CMD, WRITE_LATCH_CLEAR_CMD,
		STATUS_READ_CMD, STATUS_WRITE_CMD, READ_CMD, WRITE_CMD};
	logic        clock = 1'b0;
	logic        sys_rst, soft_reset, clk_polarity, clk_phase, tx_on, rx_on;
	logic        cs_auto, cs_setup_delay, so_hold_idle, select_level;
	logic        tx_write, done_clear, rx_read;
	logic [2:0]  rate_sel, irq_enable, irq_req, od_sel;
	logic [31:0] tx_wdata, rx_data, lfsr_reg, r;
	logic        rx_buffer_full_flag, tx_buffer_empty_flag, tx_done_flag, busy;
	logic        sclk_out, sclk_oe_n, so_out, so_oe_n, miso, cs_out, cs_oe_n;
	logic        select_port_pin, sclk_wire, mosi_wire;
	int          fails = 0;
	int          comparisons = 0;
	int          i;

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// undriven pins read high rather than a simulator guess
	assign sclk_wire = sclk_oe_n ? 1'b1 : sclk_out;
	assign mosi_wire = so_oe_n ? 1'b1 : so_out;

	frame_mode_reg_master dut_u (
		.clock(clock), .sys_rst(sys_rst), .soft_reset(soft_reset), .master_mode(1'b1),
		.clk_polarity(clk_polarity), .clk_phase(clk_phase), .msb_first(1'b1),
		.rate_sel(rate_sel), .data_len_sel(LEN_8BIT), .tx_on(tx_on), .rx_on(rx_on),
		.irq_enable(irq_enable), .open_drain_sel(od_sel), .cs_auto(cs_auto),
		.cs_setup_delay(cs_setup_delay), .so_hold_idle(so_hold_idle),
		.done_after_last(1'b1), .select_level(select_level), .tx_write(tx_write),
		.tx_wdata(tx_wdata), .done_clear(done_clear), .rx_read(rx_read), .rx_data(rx_data),
		.rx_buffer_full_flag(rx_buffer_full_flag), .tx_buffer_empty_flag(tx_buffer_empty_flag),
		.tx_done_flag(tx_done_flag), .busy(busy), .irq_req(irq_req),
		.serial_clock_pin_in(sclk_wire), .serial_clock_pin_out(sclk_out),
		.serial_clock_pin_oe_n(sclk_oe_n), .serial_out_pin_out(so_out),
		.serial_out_pin_oe_n(so_oe_n), .serial_in_pin(miso), .chip_select_pin_out(cs_out),
		.chip_select_pin_oe_n(cs_oe_n), .select_port_pin(select_port_pin)
	);

	frame_mode_reg_memory_model partner_u (
		.sclk(sclk_wire), .select_n(select_port_pin), .mosi(mosi_wire),
		.cpol(clk_polarity), .cpha(clk_phase), .miso(miso)
	);

	// ==========================================================
	// helpers
	function automatic logic [31:0] next_rand();
		lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
		return lfsr_reg;
	endfunction

	function automatic logic pick(input int which);
		case (which)
			0: return tx_buffer_empty_flag;
			1: return rx_buffer_full_flag;
			2: return tx_done_flag;
			3: return busy;
			default: return sclk_wire;
		endcase
	endfunction

	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a hung flag ends the run rather than stalling it
	task automatic wait_for(input int which, input logic lvl);
		int n;
		n = 0;
		while (n < LIMIT && pick(which) !== lvl) begin
			@(negedge clock);
			n++;
		end
		if (n >= LIMIT) begin
			fails++;
			conclude();
		end
	endtask

	// one transmit write, upper bytes random since only bits 7:0 go out
	task automatic send(input logic [7:0] b);
		r = next_rand();
		tx_wdata = {r[31:8], b};
		tx_write = 1'b1;
		@(negedge clock);
		tx_write = 1'b0;
		check(32'(tx_buffer_empty_flag), 32'h0);
		check(32'(tx_done_flag), 32'h0);
	endtask

	task automatic take(output logic [7:0] b);
		wait_for(1, 1'b1);
		b = rx_data[7:0];
		rx_read = 1'b1;
		@(negedge clock);
		rx_read = 1'b0;
		check(32'(rx_buffer_full_flag), 32'h0);
	endtask

	// ==========================================================
	// one selected transaction, at most two frames in flight
	task automatic xact(input logic [7:0] code, input logic [15:0] addr, input int ndata);
		int k, half;
		logic lvl;
		logic [7:0] seen;
		logic [7:0] frames[$];
		r = next_rand();
		clk_polarity = r[0];
		clk_phase = r[1];
		cs_auto = r[2];
		cs_setup_delay = r[3];
		so_hold_idle = r[4];
		irq_enable = r[7:5];
		od_sel = r[12:10];
		rate_sel = 3'(1 + r[9:8] % 3);
		tx_on = 1'b1;
		rx_on = 1'b1;
		repeat (3) @(negedge clock);
		check(32'(sclk_wire), 32'(clk_polarity));
		check(32'(sclk_oe_n), 32'(od_sel[1] && clk_polarity));
		select_level = 1'b0;
		repeat (2) @(negedge clock);
		check(32'(select_port_pin), 32'h0);
		frames = {code};
		if (code == READ_CMD) frames = {code, addr[15:8], addr[7:0]};
		for (k = 0; k < ndata; k++) frames.push_back(DUMMY_BYTE);
		for (k = 0; k <= frames.size(); k++) begin
			if (k < frames.size()) begin
				wait_for(0, 1'b1);
				send(frames[k]);
			end
			if (k == 0) begin
				wait_for(3, 1'b1);
				if (cs_auto) check({30'h0, cs_oe_n, cs_out}, 32'h0);
				wait_for(4, ~sclk_wire);
				lvl = sclk_wire;
				half = 0;
				while (half < LIMIT && sclk_wire === lvl) begin
					@(negedge clock);
					half++;
				end
				check(32'(half), 32'(PCLK_DIV) << rate_sel);
				if (half >= LIMIT) conclude();
			end else begin
				take(seen);
				if (code == READ_CMD && k > 3) begin
					check(32'(seen), 32'(partner_u.mem_byte(16'(addr + 16'(k - 4)))));
				end
			end
		end
		wait_for(2, 1'b1);
		@(negedge clock);
		check(32'(irq_req), 32'(((3'h1 << IRQ_TX_DONE) | (3'h1 << IRQ_TX_EMPTY))
			& irq_enable));
		select_level = 1'b1;
		done_clear = 1'b1;
		@(negedge clock);
		done_clear = 1'b0;
		tx_on = 1'b0;
		rx_on = 1'b0;
		check(32'(tx_done_flag), 32'h0);
		check(32'(select_port_pin), 32'h1);
		// let the disabled state reach the design before the next setup
		@(negedge clock);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		lfsr_reg = 32'h000133C7;
		{soft_reset, clk_polarity, clk_phase, tx_on, rx_on, cs_auto} = 6'h00;
		{cs_setup_delay, so_hold_idle, tx_write, done_clear, rx_read} = 5'h00;
		select_level = 1'b1;
		rate_sel = RATE_SEL_RESET;
		irq_enable = 3'h0;
		od_sel = 3'h0;
		tx_wdata = TX_DATA_RESET;
		sys_rst = 1'b1;
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		check({28'h0, busy, rx_buffer_full_flag, tx_done_flag, tx_buffer_empty_flag}, 32'h1);
		check(32'(select_port_pin), 32'h1);
		foreach (CODES[j]) xact(CODES[j], 16'h0000, 0);
		xact(READ_CMD, 16'h0000, 10);
		xact(READ_CMD, 16'hFFFE, 4);
		for (i = 0; i < 3; i++) begin
			r = next_rand();
			xact(READ_CMD, r[15:0], 1 + int'(r[17:16]));
		end
		// software reset in mid-frame must abandon the frame
		tx_on = 1'b1;
		rx_on = 1'b1;
		select_level = 1'b0;
		send(READ_CMD);
		wait_for(3, 1'b1);
		repeat (50) @(negedge clock);
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		check({28'h0, busy, rx_buffer_full_flag, tx_done_flag, tx_buffer_empty_flag}, 32'h1);
		// the abandoned frame must never deliver a word
		repeat (700) @(negedge clock);
		check(32'(rx_buffer_full_flag), 32'h0);
		select_level = 1'b1;
		conclude();
	end
endmodule
